// File: shared/dbg_pkg.sv
// constants, command codes and carrier types of the single-wire debug command decoder
// assumes a bit-level wire layer outside that hands over whole bytes and takes back answer bytes
// Behaviour
// - breakpoint register is 16 bits and holds a 14-bit address matched against the bus
// - breakpoint enable and force/tag select bits steer the match logic
// - breakpoint read and write work at any time without halting the cpu
// - each command opens with an 8-bit code; all fields travel msb first
// - halted-mode commands run only while halted; non-intrusive ones run anytime
// - host waits 16 to 511 debug clocks where a delay is called for
// - a 512-cycle gap after the last host falling edge ends the current command
// - only the low 14 address bits are used; bits 15 and 14 are dropped
// - a speed sync request is answered with a timed reference pulse
// - code 18 requests a full reset in any cpu mode
// - code 90 halts the cpu when halt permit is set, else is ignored
// - E4 returns the status/control byte; C4 writes it
// - E0 reads one memory byte at an address; C0 writes one during the delay
// - E1 returns status then the byte; C1 returns status after the write
// - E2 returns the 16-bit breakpoint register; C2 loads it
// - 08 leaves the halted state and resumes at the current program counter
// - 10 runs exactly one instruction and halts again
// - 80 returns bytes from incrementing addresses until a soft reset
// - 88 stores bytes at incrementing addresses until a soft reset
// - 6B returns zero flag, carry flag and 14-bit pc; 4B writes them
// - 6F returns two zero bits and the shadow pc; 4F loads it ignoring top bits
// - with breakpoint enable clear the match logic has no effect
// - force mode halts at the next boundary; tag mode tags the matching opcode
package dbg_pkg;
	// command codes
	localparam logic [7:0] CMD_TARGET_RESET = 8'h18;
	localparam logic [7:0] CMD_HALT = 8'h90;
	localparam logic [7:0] CMD_STATUS_RD = 8'he4;
	localparam logic [7:0] CMD_CTRL_WR = 8'hc4;
	localparam logic [7:0] CMD_MEM_RD = 8'he0;
	localparam logic [7:0] CMD_MEM_RD_FLAGS = 8'he1;
	localparam logic [7:0] CMD_MEM_WR = 8'hc0;
	localparam logic [7:0] CMD_MEM_WR_FLAGS = 8'hc1;
	localparam logic [7:0] CMD_MATCH_RD = 8'he2;
	localparam logic [7:0] CMD_MATCH_WR = 8'hc2;
	localparam logic [7:0] CMD_GO = 8'h08;
	localparam logic [7:0] CMD_STEP = 8'h10;
	localparam logic [7:0] CMD_BLOCK_RD = 8'h80;
	localparam logic [7:0] CMD_BLOCK_WR = 8'h88;
	localparam logic [7:0] CMD_ACC_RD = 8'h68;
	localparam logic [7:0] CMD_ACC_WR = 8'h48;
	localparam logic [7:0] CMD_FLAGS_PC_RD = 8'h6b;
	localparam logic [7:0] CMD_FLAGS_PC_WR = 8'h4b;
	localparam logic [7:0] CMD_SHADOW_RD = 8'h6f;
	localparam logic [7:0] CMD_SHADOW_WR = 8'h4f;
	// status/control field positions
	localparam int SC_PERMIT = 7;
	localparam int SC_ACTIVE = 6;
	localparam int SC_BKPT_EN = 5;
	localparam int SC_FTS = 4;
	localparam int SC_WS = 2;
	localparam int SC_WSF = 1;
	// reset values
	localparam logic [15:0] MATCH_RESET = 16'h0000;
	localparam logic CTRL_BIT_RESET = 1'b0;
	// timing counts in debug clock cycles, then the address width
	localparam int DELAY_MIN_CYC = 16;
	localparam int DELAY_MAX_CYC = 511;
	localparam int SOFT_RESET_CYC = 512;
	localparam int SYNC_PULSE_CYC = 128;
	localparam int ADDR_W = 14;

	typedef enum logic [2:0] {
		ST_CMD = 3'b000,
		ST_GATHER = 3'b001,
		ST_EXEC = 3'b010,
		ST_MEM = 3'b011,
		ST_SEND = 3'b100
	} dec_state_t;

	// one-cycle requests to the cpu core
	typedef struct packed {
		logic reset;
		logic halt;
		logic go;
		logic step;
		logic acc_wr;
		logic flags_pc_wr;
		logic shadow_wr;
	} cpu_cmd_t;

	// memory access port, request held until acknowledged or dropped by a soft reset
	typedef struct packed {
		logic req;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} mem_port_t;

	typedef struct packed {
		dec_state_t st;
		logic [7:0] cmd;
		logic [1:0] need;
		logic [1:0] left;
		logic blk;
		logic [15:0] resp;
		logic tx_valid;
		logic permit;
		logic bken;
		logic force_tag_select;
		logic [15:0] match;
		mem_port_t mem;
		cpu_cmd_t cpu;
		logic [15:0] cpu_wdata;
		logic sync_out;
		logic bk_force;
		logic bk_tag;
	} dec_reg_t;
endpackage : dbg_pkg

// File: rtl/field_shift.sv
// msb-first byte assembler for command address and data fields
// assumes bytes arrive already framed by the wire layer
`timescale 1ns/1ns
module field_shift import dbg_pkg::*; #(
	parameter int W = 24
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic clear,
	input wire logic load,
	input wire logic [7:0] byte_in,
	output logic [W-1:0] value
);
	typedef struct packed {
		logic [W-1:0] val;
	} shf_t;
	shf_t s_q, s_d;

	// earlier bytes move up, newest byte lands low
	always_comb begin
		s_d = s_q;
		if (clear)
			s_d.val = '0;
		if (load)
			s_d.val = {s_d.val[W-9:0], byte_in};
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign value = s_q.val;
endmodule : field_shift

// File: rtl/gap_timer.sv
// saturating cycle counter that pulses once when LIMIT cycles pass after restart
// assumes restart is a single-cycle event in the same clock domain
`timescale 1ns/1ns
module gap_timer import dbg_pkg::*; #(
	parameter int LIMIT = 512
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic restart,
	output logic hit
);
	localparam int CW = $clog2(LIMIT + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic hit;
	} tmr_t;
	tmr_t s_q, s_d;

	// count up to LIMIT and hold there
	always_comb begin
		s_d = s_q;
		s_d.hit = 1'b0;
		if (restart)
			s_d.cnt = '0;
		else if (s_q.cnt != CW'(LIMIT)) begin
			s_d.cnt = s_q.cnt + CW'(1);
			s_d.hit = (s_q.cnt == CW'(LIMIT - 1));
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign hit = s_q.hit;
endmodule : gap_timer

// File: rtl/cmd_decoder.sv
// command decoder of the single-wire debug port, with breakpoint match and status/control
// assumes the wire layer delivers host bytes on RX_VALID, marks host falling edges on HOST_FALL
// and shifts TX_BYTE out, pulsing TX_TAKEN once the host has clocked it
`timescale 1ns/1ns
module cmd_decoder import dbg_pkg::*; (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_BYTE,
	input wire logic HOST_FALL,
	input wire logic SYNC_REQ,
	input wire logic TX_TAKEN,
	output logic TX_VALID,
	output logic [7:0] TX_BYTE,
	output logic SYNC_PULSE,
	input wire logic MEM_ACK,
	input wire logic [7:0] MEM_RDATA,
	output mem_port_t MEM_OUT,
	input wire logic CPU_HALTED,
	input wire logic CPU_WAIT_STOP,
	input wire logic MEM_FAIL,
	input wire logic [7:0] ACC_IN,
	input wire logic [1:0] FLAGS_IN,
	input wire logic [ADDR_W-1:0] PC_IN,
	input wire logic [ADDR_W-1:0] SHADOW_IN,
	output cpu_cmd_t CPU_CTRL,
	output logic [15:0] CPU_WDATA,
	input wire logic BUS_VALID,
	input wire logic OPCODE_FETCH,
	input wire logic [ADDR_W-1:0] BUS_ADDR,
	output logic BKPT_FORCE,
	output logic BKPT_TAG
);
	dec_reg_t s_q, s_d;
	logic fld_clr;
	logic fld_load;
	logic [1:0] gather_n;
	logic [23:0] fld;
	logic soft_hit;
	logic sync_hit;
	logic [7:0] stat;
	logic match_hit;

	// assembles address and data fields of the current command
	field_shift #(.W(24)) u_field (
		.clk(MCLK),
		.nrst(NRST),
		.ce(CE),
		.clear(fld_clr),
		.load(fld_load),
		.byte_in(RX_BYTE),
		.value(fld)
	);

	// idle gap since the last host falling edge
	gap_timer #(.LIMIT(SOFT_RESET_CYC)) u_gap (
		.clk(MCLK),
		.nrst(NRST),
		.ce(CE),
		.restart(HOST_FALL),
		.hit(soft_hit)
	);

	// width of the speed reference pulse; the pulse drops one cycle after the hit, so count one less
	gap_timer #(.LIMIT(SYNC_PULSE_CYC - 1)) u_sync (
		.clk(MCLK),
		.nrst(NRST),
		.ce(CE),
		.restart(SYNC_REQ),
		.hit(sync_hit)
	);

	// status byte: permit, active, enable, select, ws, wsf; other bits read zero
	always_comb begin
		stat = 8'h00;
		stat[SC_PERMIT] = s_q.permit;
		stat[SC_ACTIVE] = CPU_HALTED;
		stat[SC_BKPT_EN] = s_q.bken;
		stat[SC_FTS] = s_q.force_tag_select;
		stat[SC_WS] = CPU_WAIT_STOP;
		stat[SC_WSF] = MEM_FAIL;
	end

	assign match_hit = (BUS_ADDR == s_q.match[ADDR_W-1:0]);

	// command sequencer
	always_comb begin
		s_d = s_q;
		fld_clr = 1'b0;
		fld_load = 1'b0;
		gather_n = 2'd0;
		s_d.cpu = '0;
		// breakpoint match works in every state, also while running
		s_d.bk_force = s_q.bken && s_q.force_tag_select && BUS_VALID && match_hit;
		s_d.bk_tag = s_q.bken && !s_q.force_tag_select && OPCODE_FETCH && match_hit;
		// reference pulse starts on request and ends on the timer
		if (SYNC_REQ)
			s_d.sync_out = 1'b1;
		else if (sync_hit)
			s_d.sync_out = 1'b0;
		case (s_q.st)
			ST_CMD: begin
				if (RX_VALID) begin
					s_d.cmd = RX_BYTE;
					s_d.blk = 1'b0;
					case (RX_BYTE)
						CMD_TARGET_RESET: s_d.cpu.reset = 1'b1;
						CMD_HALT: s_d.cpu.halt = s_q.permit;
						CMD_STATUS_RD: begin
							s_d.resp = {stat, 8'h00};
							s_d.left = 2'd1;
							s_d.st = ST_SEND;
						end
						CMD_MATCH_RD: begin
							s_d.resp = s_q.match;
							s_d.left = 2'd2;
							s_d.st = ST_SEND;
						end
						CMD_CTRL_WR: gather_n = 2'd1;
						CMD_MATCH_WR: gather_n = 2'd2;
						CMD_MEM_RD, CMD_MEM_RD_FLAGS: gather_n = 2'd2;
						CMD_MEM_WR, CMD_MEM_WR_FLAGS: gather_n = 2'd3;
						CMD_GO: s_d.cpu.go = CPU_HALTED;
						CMD_STEP: s_d.cpu.step = CPU_HALTED;
						CMD_ACC_RD, CMD_FLAGS_PC_RD, CMD_SHADOW_RD: begin
							if (CPU_HALTED) begin
								if (RX_BYTE == CMD_ACC_RD)
									s_d.resp = {ACC_IN, 8'h00};
								else if (RX_BYTE == CMD_FLAGS_PC_RD)
									s_d.resp = {FLAGS_IN, PC_IN};
								else
									s_d.resp = {2'b00, SHADOW_IN};
								s_d.left = (RX_BYTE == CMD_ACC_RD) ? 2'd1 : 2'd2;
								s_d.st = ST_SEND;
							end
						end
						CMD_ACC_WR: gather_n = CPU_HALTED ? 2'd1 : 2'd0;
						CMD_FLAGS_PC_WR, CMD_SHADOW_WR, CMD_BLOCK_RD: gather_n = CPU_HALTED ? 2'd2 : 2'd0;
						CMD_BLOCK_WR: gather_n = CPU_HALTED ? 2'd3 : 2'd0;
						default: ;
					endcase
				end
			end
			ST_GATHER: begin
				fld_load = RX_VALID;
				if (RX_VALID) begin
					s_d.need = s_q.need - 2'd1;
					if (s_q.need == 2'd1)
						s_d.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				s_d.st = ST_CMD;
				case (s_q.cmd)
					CMD_CTRL_WR: begin
						s_d.bken = fld[SC_BKPT_EN];
						s_d.force_tag_select = fld[SC_FTS];
						// permit cannot be changed while already halted
						if (!CPU_HALTED)
							s_d.permit = fld[SC_PERMIT];
					end
					CMD_MATCH_WR: s_d.match = fld[15:0];
					CMD_ACC_WR: begin
						s_d.cpu.acc_wr = 1'b1;
						s_d.cpu_wdata = {8'h00, fld[7:0]};
					end
					CMD_FLAGS_PC_WR: begin
						s_d.cpu.flags_pc_wr = 1'b1;
						s_d.cpu_wdata = fld[15:0];
					end
					CMD_SHADOW_WR: begin
						s_d.cpu.shadow_wr = 1'b1;
						s_d.cpu_wdata = {2'b00, fld[ADDR_W-1:0]};
					end
					CMD_MEM_RD, CMD_MEM_RD_FLAGS, CMD_BLOCK_RD: begin
						s_d.mem.addr = fld[ADDR_W-1:0];
						s_d.mem.req = 1'b1;
						s_d.mem.wr = 1'b0;
						s_d.st = ST_MEM;
					end
					CMD_MEM_WR, CMD_MEM_WR_FLAGS, CMD_BLOCK_WR: begin
						// block write continues at the incremented address
						s_d.mem.addr = s_q.blk ? s_q.mem.addr : fld[ADDR_W+7:8];
						s_d.mem.wdata = fld[7:0];
						s_d.mem.req = 1'b1;
						s_d.mem.wr = 1'b1;
						s_d.st = ST_MEM;
					end
					default: ;
				endcase
			end
			ST_MEM: begin
				// the access finishes inside the host's delay, the answer follows the ack
				if (MEM_ACK) begin
					s_d.mem.req = 1'b0;
					s_d.st = ST_CMD;
					case (s_q.cmd)
						CMD_MEM_RD, CMD_BLOCK_RD: begin
							s_d.resp = {MEM_RDATA, 8'h00};
							s_d.left = 2'd1;
							s_d.st = ST_SEND;
						end
						CMD_MEM_RD_FLAGS: begin
							s_d.resp = {stat, MEM_RDATA};
							s_d.left = 2'd2;
							s_d.st = ST_SEND;
						end
						CMD_MEM_WR_FLAGS: begin
							s_d.resp = {stat, 8'h00};
							s_d.left = 2'd1;
							s_d.st = ST_SEND;
						end
						CMD_BLOCK_WR: begin
							s_d.mem.addr = s_q.mem.addr + ADDR_W'(1);
							s_d.blk = 1'b1;
							gather_n = 2'd1;
						end
						default: ;
					endcase
				end
			end
			ST_SEND: begin
				if (TX_TAKEN) begin
					s_d.resp = {s_q.resp[7:0], 8'h00};
					s_d.left = s_q.left - 2'd1;
					if (s_q.left == 2'd1) begin
						s_d.st = ST_CMD;
						if (s_q.cmd == CMD_BLOCK_RD) begin
							s_d.mem.addr = s_q.mem.addr + ADDR_W'(1);
							s_d.mem.req = 1'b1;
							s_d.mem.wr = 1'b0;
							s_d.st = ST_MEM;
						end
					end
				end
			end
			default: s_d.st = ST_CMD;
		endcase
		// enter field collection
		if (gather_n != 2'd0) begin
			s_d.need = gather_n;
			s_d.st = ST_GATHER;
			fld_clr = 1'b1;
		end
		// idle gap aborts whatever command is in progress
		if (soft_hit) begin
			s_d.st = ST_CMD;
			s_d.mem.req = 1'b0;
			s_d.blk = 1'b0;
		end
		s_d.tx_valid = (s_d.st == ST_SEND);
	end

	// state register, frozen while CE is low
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			s_q <= '0;
			s_q.st <= ST_CMD;
			s_q.match <= MATCH_RESET;
			s_q.permit <= CTRL_BIT_RESET;
		end else if (CE)
			s_q <= s_d;
	end

	// outputs straight from the state register
	assign TX_VALID = s_q.tx_valid;
	assign TX_BYTE = s_q.resp[15:8];
	assign SYNC_PULSE = s_q.sync_out;
	assign MEM_OUT = s_q.mem;
	assign CPU_CTRL = s_q.cpu;
	assign CPU_WDATA = s_q.cpu_wdata;
	assign BKPT_FORCE = s_q.bk_force;
	assign BKPT_TAG = s_q.bk_tag;

	default clocking dc @(posedge MCLK); endclocking
	default disable iff (!NRST || !CE);

	sequence s_code(logic [7:0] c);
		s_q.st == ST_CMD && RX_VALID && RX_BYTE == c;
	endsequence

	reset_request_a: assert property (s_code(CMD_TARGET_RESET) |=> CPU_CTRL.reset)
		else $error("reset code did not raise reset request");
	halt_gate_a: assert property (s_code(CMD_HALT) |=> CPU_CTRL.halt == $past(s_q.permit))
		else $error("halt request disagrees with halt permit");
	go_running_a: assert property (s_code(CMD_GO) and !CPU_HALTED |=> !CPU_CTRL.go && s_q.st == ST_CMD)
		else $error("go accepted while running");
	status_reply_a: assert property (s_code(CMD_STATUS_RD) |=> TX_VALID && TX_BYTE == $past(stat))
		else $error("status byte not presented");
	match_load_a: assert property (s_q.st == ST_EXEC && s_q.cmd == CMD_MATCH_WR
		|=> s_q.match == $past(fld[15:0]) && s_q.st == ST_CMD)
		else $error("breakpoint register not loaded");
	force_hit_a: assert property (BUS_VALID && s_q.bken && s_q.force_tag_select && match_hit |=> BKPT_FORCE)
		else $error("force breakpoint missed");
	bkpt_off_a: assert property (!s_q.bken |=> !BKPT_FORCE && !BKPT_TAG)
		else $error("breakpoint acted while disabled");
	soft_abort_a: assert property (soft_hit |=> s_q.st == ST_CMD && !MEM_OUT.req)
		else $error("soft reset did not end command");
	addr_trunc_a: assert property (s_q.st == ST_EXEC && s_q.cmd == CMD_MEM_RD
		|=> MEM_OUT.req && MEM_OUT.addr == $past(fld[ADDR_W-1:0]))
		else $error("read address not truncated to 14 bits");
	block_next_a: assert property (s_q.st == ST_SEND && s_q.cmd == CMD_BLOCK_RD && TX_TAKEN
		&& s_q.left == 2'd1 && !soft_hit |=> MEM_OUT.req && MEM_OUT.addr == $past(s_q.mem.addr) + 14'h0001)
		else $error("block read did not advance address");
	sync_width_a: assert property (SYNC_REQ |=> SYNC_PULSE [*8])
		else $error("reference pulse too short");
endmodule : cmd_decoder

// File: testbench/cpu_mem_model.sv
// target memory seen by the decoder's memory port, with prompt or slow answers
// assumes the request is held until ack, and ack is sampled on the rising clock edge
`timescale 1ns/1ns
module cpu_mem_model import dbg_pkg::*; (
	input wire logic clk,
	input wire logic slow,
	input wire mem_port_t mem,
	output logic ack,
	output logic [7:0] rdata
);
	logic [7:0] store [int];
	logic [7:0] last = 8'h00;
	int wait_q = 0;

	// unwritten places read as their low address byte xor a5
	function automatic logic [7:0] peek(input logic [13:0] a);
		return store.exists(a) ? store[a] : a[7:0] ^ 8'ha5;
	endfunction : peek

	initial begin
		ack = 1'b0;
		rdata = 8'h00;
	end

	// answer after one or six cycles; data lines flip when not answering
	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~last;
		if (mem.req && !ack) begin
			if (wait_q < (slow ? 5 : 0)) begin
				wait_q <= wait_q + 1;
			end else begin
				wait_q <= 0;
				ack <= 1'b1;
				if (mem.wr) begin
					store[mem.addr] = mem.wdata;
				end else begin
					rdata <= peek(mem.addr);
					last <= peek(mem.addr);
				end
			end
		end
	end
endmodule : cpu_mem_model

// File: testbench/cmd_decoder_tb.sv
// self-checking bench of the debug command decoder; the bench plays the host
// assumes the memory model above and drives all inputs on the falling edge
`timescale 1ns/1ns
module cmd_decoder_tb import dbg_pkg::*; ;
	logic MCLK = 0, NRST = 0, CE = 1, RX_VALID = 0, HOST_FALL = 0, SYNC_REQ = 0, TX_TAKEN = 0;
	logic CPU_HALTED = 0, CPU_WAIT_STOP = 0, MEM_FAIL = 0, BUS_VALID = 0, OPCODE_FETCH = 0, slow = 0;
	logic [7:0] RX_BYTE = 8'h00, ACC_IN = 8'h77;
	logic [1:0] FLAGS_IN = 2'b10;
	logic [13:0] PC_IN = 14'h1234, SHADOW_IN = 14'h2abc, BUS_ADDR = 14'h0000;
	logic TX_VALID, SYNC_PULSE, MEM_ACK, BKPT_FORCE, BKPT_TAG;
	logic [7:0] TX_BYTE, MEM_RDATA;
	logic [15:0] CPU_WDATA;
	mem_port_t MEM_OUT;
	cpu_cmd_t CPU_CTRL;
	logic [6:0] seen = 7'h00;
	int num_errors = 0, n_checks = 0, cyc = 0;

	cmd_decoder u_dut (.MCLK(MCLK), .NRST(NRST), .CE(CE), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
		.HOST_FALL(HOST_FALL), .SYNC_REQ(SYNC_REQ), .TX_TAKEN(TX_TAKEN), .TX_VALID(TX_VALID),
		.TX_BYTE(TX_BYTE), .SYNC_PULSE(SYNC_PULSE), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
		.MEM_OUT(MEM_OUT), .CPU_HALTED(CPU_HALTED), .CPU_WAIT_STOP(CPU_WAIT_STOP), .MEM_FAIL(MEM_FAIL),
		.ACC_IN(ACC_IN), .FLAGS_IN(FLAGS_IN), .PC_IN(PC_IN), .SHADOW_IN(SHADOW_IN), .CPU_CTRL(CPU_CTRL),
		.CPU_WDATA(CPU_WDATA), .BUS_VALID(BUS_VALID), .OPCODE_FETCH(OPCODE_FETCH), .BUS_ADDR(BUS_ADDR),
		.BKPT_FORCE(BKPT_FORCE), .BKPT_TAG(BKPT_TAG));
	cpu_mem_model u_mem (.clk(MCLK), .slow(slow), .mem(MEM_OUT), .ack(MEM_ACK), .rdata(MEM_RDATA));

	// 50 MHz clock, cycle limit, sticky record of cpu pulses
	always #10 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		seen <= seen | CPU_CTRL;
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test;
		end
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(negedge MCLK);
	endtask : idle

	// one host byte, with the falling edge that restarts the gap timer
	task automatic send(input logic [7:0] b);
		idle(2);
		RX_VALID = 1;
		RX_BYTE = b;
		HOST_FALL = 1;
		@(negedge MCLK);
		RX_VALID = 0;
		HOST_FALL = 0;
		RX_BYTE = ~b;
	endtask : send

	task automatic cmd3(input logic [7:0] c, input logic [15:0] a);
		send(c);
		send(a[15:8]);
		send(a[7:0]);
	endtask : cmd3

	// wait for an answer byte, judge it, then let the host clock it out
	task automatic recv(input logic [7:0] exp);
		for (int i = 0; i < 40 && TX_VALID !== 1'b1; i++) @(negedge MCLK);
		chk({TX_VALID, TX_BYTE}, {1'b1, exp});
		TX_TAKEN = 1;
		HOST_FALL = 1;
		@(negedge MCLK);
		TX_TAKEN = 0;
		HOST_FALL = 0;
	endtask : recv

	task automatic ctrl(input logic [7:0] b);
		send(CMD_CTRL_WR);
		send(b);
	endtask : ctrl

	task automatic pulse(input logic [7:0] c, input logic [6:0] exp);
		seen = 7'h00;
		send(c);
		idle(4);
		chk(seen, exp);
	endtask : pulse

	task automatic bus(input logic [13:0] a, input logic f, input logic [1:0] exp);
		@(negedge MCLK);
		BUS_VALID = 1;
		OPCODE_FETCH = f;
		BUS_ADDR = a;
		@(negedge MCLK);
		BUS_VALID = 0;
		OPCODE_FETCH = 0;
		chk({BKPT_FORCE, BKPT_TAG}, exp);
	endtask : bus

	task automatic t_regs;
		send(CMD_MATCH_RD);
		recv(8'h00);
		recv(8'h00);
		seen = 7'h00;
		cmd3(CMD_MATCH_WR, 16'hc123);
		send(CMD_MATCH_RD);
		recv(8'hc1);
		recv(8'h23);
		chk(seen, 7'h00);
		CPU_WAIT_STOP = 1;
		MEM_FAIL = 1;
		ctrl(8'hb0);
		send(CMD_STATUS_RD);
		recv(8'hb6);
		CPU_HALTED = 1;
		ctrl(8'h00);
		send(CMD_STATUS_RD);
		recv(8'hc6);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_bkpt;
		ctrl(8'h10);
		bus(14'h0123, 1, 2'b00);
		ctrl(8'h30);
		bus(14'h0123, 0, 2'b10);
		bus(14'h0124, 0, 2'b00);
		ctrl(8'h20);
		bus(14'h0123, 1, 2'b01);
		bus(14'h0123, 0, 2'b00);
		$display("t_bkpt done");
	endtask : t_bkpt

	task automatic t_mem;
		CPU_HALTED = 0;
		ctrl(8'h00);
		slow = 1;
		cmd3(CMD_MEM_WR, 16'h4005);
		send(8'h3c);
		idle(16);
		cmd3(CMD_MEM_RD_FLAGS, 16'h0005);
		recv(8'h06);
		recv(8'h3c);
		slow = 0;
		cmd3(CMD_MEM_WR_FLAGS, 16'h8006);
		send(8'h5d);
		recv(8'h06);
		cmd3(CMD_MEM_RD, 16'hc006);
		recv(8'h5d);
		cmd3(CMD_MEM_RD, 16'h000a);
		recv(8'haf);
		$display("t_mem done");
	endtask : t_mem

	task automatic t_cpu;
		pulse(CMD_HALT, 7'h00);
		pulse(CMD_GO, 7'h00);
		pulse(8'h5a, 7'h00);
		pulse(CMD_TARGET_RESET, 7'h40);
		ctrl(8'h80);
		pulse(CMD_HALT, 7'h20);
		CPU_HALTED = 1;
		pulse(CMD_GO, 7'h10);
		pulse(CMD_STEP, 7'h08);
		send(CMD_FLAGS_PC_RD);
		recv(8'h92);
		recv(8'h34);
		send(CMD_SHADOW_RD);
		recv(8'h2a);
		recv(8'hbc);
		seen = 7'h00;
		cmd3(CMD_SHADOW_WR, 16'hff11);
		idle(4);
		chk(seen, 7'h01);
		chk(CPU_WDATA, 16'h3f11);
		seen = 7'h00;
		cmd3(CMD_FLAGS_PC_WR, 16'h5678);
		idle(4);
		chk(seen, 7'h02);
		chk(CPU_WDATA, 16'h5678);
		send(CMD_ACC_RD);
		recv(8'h77);
		seen = 7'h00;
		send(CMD_ACC_WR);
		send(8'h9e);
		idle(4);
		chk(seen, 7'h04);
		chk(CPU_WDATA, 16'h009e);
		$display("t_cpu done");
	endtask : t_cpu

	task automatic t_block;
		cmd3(CMD_BLOCK_WR, 16'h0020);
		send(8'ha0);
		idle(16);
		send(8'ha1);
		idle(16);
		send(8'ha2);
		idle(530);
		chk(MEM_OUT.req, 1'b0);
		send(CMD_STATUS_RD);
		recv(8'hc6);
		cmd3(CMD_BLOCK_RD, 16'h001f);
		recv(8'hba);
		recv(8'ha0);
		recv(8'ha1);
		recv(8'ha2);
		idle(530);
		chk({TX_VALID, MEM_OUT.req}, 2'b00);
		$display("t_block done");
	endtask : t_block

	task automatic t_sync;
		int n;
		n = 0;
		@(negedge MCLK);
		SYNC_REQ = 1;
		@(negedge MCLK);
		SYNC_REQ = 0;
		repeat (200) begin
			if (SYNC_PULSE === 1'b1) n++;
			@(negedge MCLK);
		end
		chk(16'(n), 16'(SYNC_PULSE_CYC));
		$display("t_sync done");
	endtask : t_sync

	// ce low freezes a pending answer; a mid-run reset clears the breakpoint register
	task automatic t_reset;
		send(CMD_MATCH_RD);
		for (int i = 0; i < 8 && TX_VALID !== 1'b1; i++) @(negedge MCLK);
		CE = 0;
		TX_TAKEN = 1;
		@(negedge MCLK);
		TX_TAKEN = 0;
		CE = 1;
		recv(8'hc1);
		recv(8'h23);
		NRST = 0;
		idle(2);
		NRST = 1;
		chk({TX_VALID, SYNC_PULSE, MEM_OUT.req, CPU_CTRL}, 16'h0000);
		send(CMD_MATCH_RD);
		recv(8'h00);
		recv(8'h00);
		$display("t_reset done");
	endtask : t_reset

	// reset for 16 cycles, then the scenarios in turn
	initial begin
		idle(16);
		NRST = 1;
		chk({TX_VALID, SYNC_PULSE, MEM_OUT.req, CPU_CTRL}, 16'h0000);
		t_regs;
		t_bkpt;
		t_mem;
		t_cpu;
		t_block;
		t_sync;
		t_reset;
		end_of_test;
	end
endmodule : cmd_decoder_tb
